// ---- core/uart_baud_sample_timing.sv ----
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_regs.svh"

// How it works
// - sample position resets to six, four-bit field
// - programmed position used only in manual mode
// - oversample periods counted from zero per bit
// - automatic start period follows oversample rate
// - manual mode starts samples at programmed field
// - bit rate is clock over O*N*P
// - divisor divides by programmed value plus one
// - half-step prescaler factors from 1.0 to 15.5
// - oversample codes 0-6 give sixteen, else value
// - mode bit clear automatic, set uses register
module uart_baud_sample_timing
(
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic [31:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [31:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   rxd,
   input  wire logic                   bitRestart,
   output uart_baud_pkg::baud_tick_t   ticks,
   output uart_baud_pkg::sample_t      sample
);
   import uart_baud_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [4:0] osRateOf(input logic [3:0] code);
      osRateOf = (code < `OVR_CODE_MIN) ? `OVR_RATE_MAX : {1'b0, code};
   endfunction

   function automatic logic byteHit(input logic [31:0] addr, input logic [7:0] ofs);
      byteHit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [3:0]  overReg;
   logic        modeReg;
   logic [7:0]  posReg;
   logic [4:0]  pselReg;
   logic [11:0] divReg;

   logic        awHeld_reg;
   logic        wHeld_reg;
   logic [31:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0]  wStrb_reg;
   logic        bValid_reg;
   logic [1:0]  bResp_reg;
   logic        rValid_reg;
   logic [1:0]  rResp_reg;
   logic [31:0] rData_reg;
   logic        doWrite;
   logic        wrMapped;

   assign s_axi_awready = !awHeld_reg;
   assign s_axi_wready  = !wHeld_reg;
   assign s_axi_bvalid  = bValid_reg;
   assign s_axi_bresp   = bResp_reg;
   assign s_axi_arready = !rValid_reg;
   assign s_axi_rvalid  = rValid_reg;
   assign s_axi_rresp   = rResp_reg;
   assign s_axi_rdata   = rData_reg;

   assign doWrite  = awHeld_reg && wHeld_reg && !bValid_reg;
   assign wrMapped = byteHit(awAddr_reg, `OFS_OVERSAMPLE) || byteHit(awAddr_reg, `OFS_MODE2)
                  || byteHit(awAddr_reg, `OFS_SAMPLE_POS) || byteHit(awAddr_reg, `OFS_PRESCALER)
                  || byteHit(awAddr_reg, `OFS_BAUD_DIV) || byteHit(awAddr_reg, `OFS_STATUS);

   // address and data are latched apart so either may arrive first
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         awAddr_reg <= 32'h00000000;
         wData_reg  <= 32'h00000000;
         wStrb_reg  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && !awHeld_reg)
         begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         else if (doWrite)
            awHeld_reg <= 1'b0;
         if (s_axi_wvalid && !wHeld_reg)
         begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         else if (doWrite)
            wHeld_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         bValid_reg <= 1'b0;
         bResp_reg  <= `RESP_OKAY;
      end
      else if (doWrite)
      begin
         bValid_reg <= 1'b1;
         bResp_reg  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
         bValid_reg <= 1'b0;
   end

   // status is read-only; writes to it are accepted and dropped
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         overReg <= `RST_OVERSAMPLE;
         modeReg <= `RST_MODE2;
         posReg  <= `RST_SAMPLE_POS;
         pselReg <= `RST_PRESCALER;
         divReg  <= `RST_BAUD_DIV;
      end
      else if (doWrite)
      begin
         if (wStrb_reg[0] && byteHit(awAddr_reg, `OFS_OVERSAMPLE))
            overReg <= wData_reg[3:0];
         if (wStrb_reg[0] && byteHit(awAddr_reg, `OFS_MODE2))
            modeReg <= wData_reg[0];
         if (wStrb_reg[0] && byteHit(awAddr_reg, `OFS_SAMPLE_POS))
            posReg <= {4'h0, wData_reg[3:0]};
         if (wStrb_reg[0] && byteHit(awAddr_reg, `OFS_PRESCALER))
            pselReg <= wData_reg[4:0];
         if (wStrb_reg[0] && byteHit(awAddr_reg, `OFS_BAUD_DIV))
            divReg[7:0] <= wData_reg[7:0];
         if (wStrb_reg[1] && byteHit(awAddr_reg, `OFS_BAUD_DIV))
            divReg[11:8] <= wData_reg[11:8];
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   logic [3:0] osCnt;
   sample_t    sample_reg;
   logic       rxLevel;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rValid_reg <= 1'b0;
         rResp_reg  <= `RESP_OKAY;
         rData_reg  <= 32'h00000000;
      end
      else if (s_axi_arvalid && !rValid_reg)
      begin
         rValid_reg <= 1'b1;
         rResp_reg  <= `RESP_OKAY;
         if (byteHit(s_axi_araddr, `OFS_OVERSAMPLE))
            rData_reg <= {28'h0000000, overReg};
         else if (byteHit(s_axi_araddr, `OFS_MODE2))
            rData_reg <= {31'h00000000, modeReg};
         else if (byteHit(s_axi_araddr, `OFS_SAMPLE_POS))
            rData_reg <= {24'h000000, posReg};
         else if (byteHit(s_axi_araddr, `OFS_PRESCALER))
            rData_reg <= {27'h0000000, pselReg};
         else if (byteHit(s_axi_araddr, `OFS_BAUD_DIV))
            rData_reg <= {20'h00000, divReg};
         else if (byteHit(s_axi_araddr, `OFS_STATUS))
            rData_reg <= {26'h0000000, osCnt, sample_reg.value, rxLevel};
         else
         begin
            rData_reg <= 32'h00000000;
            rResp_reg <= `RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         rValid_reg <= 1'b0;
   end

   // ----------------------------------------
   // baud generation
   // ----------------------------------------
   logic [5:0]  halfAcc;
   logic [5:0]  halfSum;
   logic [5:0]  halfDiv;
   logic        presTick;
   logic [11:0] baudCnt;
   logic        osTick;
   logic [4:0]  osRate;

   // half-step factor as an accumulator; the jitter is one clock
   assign halfDiv = (pselReg > `PSC_CODE_MAX) ? ({1'b0, `PSC_CODE_MAX} + `PSC_HALF_BASE)
                                             : ({1'b0, pselReg} + `PSC_HALF_BASE);
   assign halfSum  = halfAcc + `PSC_HALF_STEP;
   assign presTick = (halfSum >= halfDiv);
   assign osRate   = osRateOf(overReg);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         halfAcc <= 6'h00;
      else if (!presTick)
         halfAcc <= halfSum;
      // a residue left from a larger factor is dropped, so the rhythm settles at once
      else if ((halfSum - halfDiv) >= halfDiv)
         halfAcc <= 6'h00;
      else
         halfAcc <= halfSum - halfDiv;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         baudCnt <= 12'h000;
         osTick  <= 1'b0;
      end
      else
      begin
         // a divisor lowered mid-count wraps at once instead of running to the top
         osTick <= presTick && (baudCnt >= divReg);
         if (presTick)
            baudCnt <= (baudCnt >= divReg) ? 12'h000 : baudCnt + 12'h001;
      end
   end

   // ----------------------------------------
   // bit phase and sampling
   // ----------------------------------------
   logic       rxMeta;
   logic       rxS2;
   logic       rxS3;
   logic       bitTick;
   logic [3:0] firstPos;
   logic [4:0] autoPos;
   logic [1:0] votes;

   // a change counts only once the second and third stages agree
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rxMeta  <= 1'b1;
         rxS2    <= 1'b1;
         rxS3    <= 1'b1;
         rxLevel <= 1'b1;
      end
      else
      begin
         rxMeta <= rxd;
         rxS2   <= rxMeta;
         rxS3   <= rxS2;
         if (rxS2 == rxS3)
            rxLevel <= rxS3;
      end
   end

   assign autoPos  = (osRate - `AUTO_POS_OFFSET) >> 1;
   // manual position only when mode bit set
   assign firstPos = modeReg ? posReg[3:0] : autoPos[3:0];

   // period count from zero to rate-1
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         osCnt   <= 4'h0;
         bitTick <= 1'b0;
      end
      else
      begin
         bitTick <= osTick && (osCnt == 4'(osRate - 5'h01));
         if (bitRestart)
            osCnt <= 4'h0;
         else if (osTick)
            osCnt <= (osCnt == 4'(osRate - 5'h01)) ? 4'h0 : osCnt + 4'h1;
      end
   end

   // position beyond rate-3 loses the last samples; software must avoid it
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         votes      <= 2'h0;
         sample_reg <= '{valid: 1'b0, value: 1'b1};
      end
      else
      begin
         sample_reg.valid <= 1'b0;
         if (osTick && !bitRestart)
         begin
            if (osCnt == firstPos)
               votes[0] <= rxLevel;
            if (osCnt == firstPos + 4'h1)
               votes[1] <= rxLevel;
            if (osCnt == firstPos + `SAMPLE_SPAN)
            begin
               sample_reg.valid <= 1'b1;
               sample_reg.value <= (votes[0] & votes[1]) | (votes[0] & rxLevel)
                                 | (votes[1] & rxLevel);
            end
         end
      end
   end

   assign ticks  = '{osTick: osTick, bitTick: bitTick, phase: osCnt};
   assign sample = sample_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence thirdSample;
      osTick && !bitRestart && (osCnt == firstPos + `SAMPLE_SPAN);
   endsequence

   a_pos_reset: assert property (disable iff (1'b0) !rst_b |=> posReg == 8'h06)
      else $error("sample position not six after reset");
   a_manual_pos: assert property ((modeReg && $past(modeReg) && sample_reg.valid)
         |-> $past(osCnt) == $past(posReg[3:0]) + 4'h2)
      else $error("manual sampling off programmed position");
   a_phase_wrap: assert property ((osTick && !bitRestart && osCnt == 4'(osRate - 5'h01))
         |=> osCnt == 4'h0)
      else $error("phase count did not wrap at rate");
   a_auto_pos: assert property ((!modeReg && osRate == 5'h10 && $stable(overReg)
         && $past(!modeReg) && sample_reg.valid) |-> $past(osCnt) == 4'h8)
      else $error("automatic third sample not at period eight");
   a_sample_ends: assert property (thirdSample |=> sample_reg.valid)
      else $error("no result after third sample");
   a_div_hold: assert property ((presTick && baudCnt < divReg) |=> !osTick)
      else $error("oversample tick before divisor count");
   a_psc_unity: assert property ((pselReg == 5'h00 && $past(pselReg) == 5'h00)
         |-> presTick)
      else $error("unity prescaler missed a tick");
   a_psc_gap: assert property ((pselReg == 5'h02 && $stable(pselReg) && presTick)
         |=> !presTick ##1 presTick)
      else $error("factor two prescaler rhythm wrong");
   a_majority: assert property ((thirdSample and (votes[0] == votes[1]))
         |=> sample_reg.value == $past(votes[0]))
      else $error("agreeing samples outvoted");
   a_rate_low: assert property ((overReg < 4'h7) |-> osRate == 5'h10)
      else $error("low code not sixteen");

endmodule
`default_nettype wire

// ---- core/uart_baud_regs.svh ----
`ifndef UART_BAUD_REGS_SVH
`define UART_BAUD_REGS_SVH

// register byte offsets
`define OFS_OVERSAMPLE   8'h00
`define OFS_MODE2        8'h04
`define OFS_SAMPLE_POS   8'h08
`define OFS_PRESCALER    8'h0C
`define OFS_BAUD_DIV     8'h10
`define OFS_STATUS       8'h14

// reset values
`define RST_OVERSAMPLE   4'h0
`define RST_MODE2        1'h0
`define RST_SAMPLE_POS   8'h06
`define RST_PRESCALER    5'h00
`define RST_BAUD_DIV     12'h000

// oversample decode
`define OVR_CODE_MIN     4'h7
`define OVR_RATE_MAX     5'h10
`define AUTO_POS_OFFSET  5'h03
`define SAMPLE_SPAN      4'h2

// prescaler in half steps: half-units = code + 2, capped
`define PSC_HALF_BASE    6'h02
`define PSC_HALF_STEP    6'h02
`define PSC_CODE_MAX     5'h1D

// bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ---- core/uart_baud_pkg.sv ----
package uart_baud_pkg;

   typedef struct packed {
      logic valid;
      logic value;
   } sample_t;

   typedef struct packed {
      logic       osTick;
      logic       bitTick;
      logic [3:0] phase;
   } baud_tick_t;

endpackage

// ---- verif/uart_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// remote line model
// ----------------------------------------
module uart_line_model
(
   input  wire logic        clk,
   input  wire logic [3:0]  phase,
   input  wire logic [15:0] lowMask,
   output logic             rxd
);
   // zero rate error
   // locked to the receiver's own period count, so no drift between the two ends
   always @(posedge clk)
   begin
      rxd <= !lowMask[phase];
   end
endmodule
`default_nettype wire

// ---- verif/uart_baud_sample_timing_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_regs.svh"
module uart_baud_sample_timing_tb;
   import uart_baud_pkg::*;
   logic        clk, rst_b, bitRestart, rxd;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] lowMask;
   baud_tick_t  ticks;
   sample_t     sample;
   int          errors, checksDone, cyc;

   uart_baud_sample_timing dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .bitRestart, .ticks, .sample);
   uart_line_model line (.clk, .phase(ticks.phase), .lowMask, .rxd);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   function automatic int rateOf(input logic [3:0] c);
      return (c < 4'h7) ? 16 : int'(c);
   endfunction

   task automatic finalReport();
      $display("checks %0d mismatches %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checksDone++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask

   task automatic tmo();
      $display("BAD wait expected answer seen timeout");
      errors++;
      finalReport();
   endtask

   task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int   n;
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (aw && s_axi_awready === 1'b1)
         begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1)
         begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1 && n < 60);
      if (s_axi_bvalid !== 1'b1) tmo();
      chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 60);
      if (s_axi_rvalid !== 1'b1) tmo();
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic waitEv(input bit bitEv, input int lim);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while ((bitEv ? ticks.bitTick : sample.valid) !== 1'b1 && n < lim);
      if ((bitEv ? ticks.bitTick : sample.valid) !== 1'b1) tmo();
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      logic [31:0] d, q;
      logic [1:0]  r;
      logic [3:0]  code;
      int          rate, fp, pos, dv, ps, t0, n;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, lowMask} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {rst_b, bitRestart, errors, checksDone} = '0;
      s_axi_wstrb = 4'hF;
      t0 = $urandom(32'h14C1);
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         axr(i * 4, d, r);
         chk("reset value", (i == 2) ? 32'h6 : 32'h0, d);
      end
      axr(32'h40, d, r);
      chk("unmapped read", 32'h2, {30'h0, r});
      axw(32'h40, $urandom, `RESP_SLVERR);
      d = $urandom;
      axw(`OFS_SAMPLE_POS, d, `RESP_OKAY);
      axr(`OFS_SAMPLE_POS, q, r);
      chk("position field", {28'h0, d[3:0]}, q);
      $display("test registers done");
      for (int k = 0; k < 6; k++)
      begin
         code = (k == 0) ? 4'h0 : 4'($urandom_range(15));
         dv = (k == 1) ? 4 : $urandom_range(3);
         ps = (k == 2) ? 29 : (k == 3) ? 31 : $urandom_range(31);
         axw(`OFS_OVERSAMPLE, 32'(code), `RESP_OKAY);
         axw(`OFS_BAUD_DIV, dv, `RESP_OKAY);
         axw(`OFS_PRESCALER, ps, `RESP_OKAY);
         // codes above the top one act as the top factor
         ps = (ps > 29) ? 29 : ps;
         waitEv(1'b1, 5000);
         t0 = cyc;
         waitEv(1'b1, 5000);
         waitEv(1'b1, 5000);
         chk("two bit periods", rateOf(code) * (dv + 1) * (ps + 2), cyc - t0);
      end
      axw(`OFS_BAUD_DIV, 9, `RESP_OKAY);
      axw(`OFS_PRESCALER, 0, `RESP_OKAY);
      n = 0;
      repeat (100)
      begin
         @(posedge clk);
         n += int'(ticks.osTick);
      end
      chk("oversample ticks", 32'h0000000A, n);
      bitRestart <= 1'b1;
      @(posedge clk);
      bitRestart <= 1'b0;
      @(posedge clk);
      chk("phase after restart", 32'h00000000, {28'h0, ticks.phase});
      $display("test bit rate done");
      for (int k = 0; k < 11; k++)
      begin
         code = (k < 9) ? 4'(k + 7) : 4'(k - 9);
         rate = rateOf(code);
         pos = $urandom_range(rate - 3);
         fp = (k % 2) ? pos : (rate + 1) / 2 - 2;
         axw(`OFS_OVERSAMPLE, 32'(code), `RESP_OKAY);
         axw(`OFS_SAMPLE_POS, pos, `RESP_OKAY);
         axw(`OFS_MODE2, k % 2, `RESP_OKAY);
         for (int p = 0; p < 2; p++)
         begin
            lowMask <= p ? (16'h1 << (fp + 1)) : ((16'h1 << fp) | (16'h1 << (fp + 2)));
            waitEv(1'b0, 1000);
            waitEv(1'b0, 1000);
            chk("voted bit", p, {31'h0, sample.value});
         end
      end
      $display("test sample position done");
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      axr(`OFS_SAMPLE_POS, q, r);
      chk("position after reset", 32'h00000006, q);
      $display("test reset done");
      finalReport();
   end
endmodule
`default_nettype wire
